// >>> verilog/rmsc_pkg.sv
// package for the relay multiplexer scan control block
// assumes a single 25 MHz clock and a plain register port from the host command side
`default_nettype none
package rmsc_pkg;
  localparam int NUM_CH = 64;
  localparam int BANK_SIZE = 32;
  localparam int NUM_TREE = 5;
  localparam logic [7:0] MAX_CH = 8'h3f;
  localparam logic [7:0] TREE_BASE = 8'h5a;   // tree relay channels 90..94
  localparam logic [7:0] TREE_LAST = 8'h5e;
  // tree relay bit positions within the tree vector
  localparam int TR_BANK_A_SENSE = 0;         // channel 90
  localparam int TR_BANK_B_SENSE = 1;         // channel 91
  localparam int TR_BANK_B_CURR = 2;          // channel 92
  localparam int TR_THERM_A = 3;              // channel 93
  localparam int TR_THERM_B = 4;              // channel 94
  // register offsets (word index = byte address / 4)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_LIST = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CH_LO = 8'h14;
  localparam logic [7:0] OFS_CH_HI = 8'h18;
  localparam logic [7:0] OFS_TREE = 8'h1c;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  // command codes in CMD[31:24], channel in CMD[7:0]
  localparam logic [7:0] CMD_CLOSE = 8'h01;
  localparam logic [7:0] CMD_OPEN = 8'h02;
  localparam logic [7:0] CMD_RESET = 8'h03;
  localparam logic [7:0] CMD_INIT = 8'h04;
  localparam logic [7:0] CMD_ABORT = 8'h05;
  // reset count, last scan list position and dwell timing
  localparam logic [15:0] RST_COUNT = 16'h0001;
  localparam logic [5:0] LIST_ENTRIES = 6'h3f;
  localparam int STEP_NS = 1000;              // dwell per scanned channel
  localparam int CLK_NS = 40;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] STEP_CYC_W = 8'(STEP_CYC);

  typedef enum logic [1:0] {
    RMSC_TRIG_IMM = 2'h0,
    RMSC_TRIG_BUS = 2'h1,
    RMSC_TRIG_EXT = 2'h2
  } rmsc_trig_e;

  typedef enum logic [1:0] {
    RMSC_MODE_NONE = 2'h0,
    RMSC_MODE_RES2 = 2'h1,
    RMSC_MODE_RES4 = 2'h2,
    RMSC_MODE_TEMP = 2'h3
  } rmsc_mode_e;

  typedef enum logic {
    RMSC_PORT_NONE = 1'b0,
    RMSC_PORT_ANALOG_BUS_PORT = 1'b1
  } rmsc_port_e;

  typedef struct packed {
    rmsc_trig_e trig_src;
    logic       cont_init;
    logic       trig_out_en;
    rmsc_mode_e scan_mode;
    rmsc_port_e analog_bus_port;
  } rmsc_cfg_s;

  localparam rmsc_cfg_s RST_CFG = '{RMSC_TRIG_IMM, 1'b0, 1'b0, RMSC_MODE_NONE, RMSC_PORT_NONE};
  localparam int CFG_W = $bits(rmsc_cfg_s);

  typedef enum logic [2:0] {
    RMSC_IDLE  = 3'b001,
    RMSC_WAIT  = 3'b010,
    RMSC_DWELL = 3'b100
  } rmsc_state_e;
endpackage
`default_nettype wire

// >>> verilog/rmsc_top.sv
// relay state and scan control for a 64-channel three-wire multiplexer
// assumes one clock, host command writes over a plain register port, read data one cycle later
//
// Implementation choices: the register offsets and strobed register access.
`default_nettype none

// Notes on behaviour
// - power-on or reset command opens all 64 channels and tree relays
// - reset command invalidates the stored scan list
// - reset sets scan cycle count to one
// - reset selects immediate trigger source
// - reset turns continuous initiation off
// - reset disables trigger output
// - reset sets scan mode to none
// - reset sets scan port to none
// - closed tree relay stays closed until open, reset or power loss
// - with analog bus port, scan closes the suitable tree relays itself
// - tree 90 joins bus sense lines to bank A channels 00-31
// - tree 91 sense and tree 92 current lines join bank B 32-63
// - tree 93 joins thermistor to bank A sense side
// - tree 94 joins thermistor to bank B current side
// - any channel can be closed or opened individually
// - only analog bus port lets scan drive trees 90-92
// - four-wire scan pairs bank A channel with channel 32 higher
module rmsc_top (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic [7:0]                  addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  input  wire logic                        ext_trig,
  output logic      [31:0]                 rdata,
  output logic      [rmsc_pkg::NUM_CH-1:0] ch_drive,
  output logic      [rmsc_pkg::NUM_TREE-1:0] tree_drive,
  output logic                             trig_out,
  output logic                             scan_busy
);
  localparam int NC = rmsc_pkg::NUM_CH;
  localparam int NT = rmsc_pkg::NUM_TREE;

  // user (switched) relay state and scan-driven state are kept apart so a scan
  // never disturbs what the host closed by hand
  logic [NC-1:0] ch_reg, ch_next;
  logic [NT-1:0] tree_reg, tree_next;
  logic [NC-1:0] scan_ch_reg, scan_ch_next;
  logic [NT-1:0] scan_tree_reg, scan_tree_next;
  rmsc_pkg::rmsc_cfg_s cfg_reg, cfg_next;
  logic [15:0] count_reg, count_next;
  logic [NC-1:0] list_reg, list_next;
  logic list_valid_reg, list_valid_next;
  rmsc_pkg::rmsc_state_e state_reg, state_next;
  logic [5:0] pos_reg, pos_next;
  logic [15:0] pass_reg, pass_next;
  logic [7:0] dwell_reg, dwell_next;
  logic bus_trig_reg, bus_trig_next;
  logic trig_out_reg, trig_out_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg, rdata_next;

  logic [7:0] cmd_op;
  logic [7:0] cmd_ch;
  logic cmd_wr;
  logic is_chan;
  logic is_tree;
  logic [2:0] tree_idx;
  logic trig_ok;
  logic four_wire;

  assign cmd_op = wdata[31:24];
  assign cmd_ch = wdata[7:0];
  assign cmd_wr = wr_en && (addr == rmsc_pkg::OFS_CMD);
  assign is_chan = (cmd_ch <= rmsc_pkg::MAX_CH);
  assign is_tree = (cmd_ch >= rmsc_pkg::TREE_BASE) && (cmd_ch <= rmsc_pkg::TREE_LAST);
  assign tree_idx = 3'(cmd_ch - rmsc_pkg::TREE_BASE);
  assign four_wire = (cfg_reg.scan_mode == rmsc_pkg::RMSC_MODE_RES4);

  // next relay and configuration state
  always_comb begin
    ch_next = ch_reg;
    tree_next = tree_reg;
    cfg_next = cfg_reg;
    count_next = count_reg;
    list_next = list_reg;
    list_valid_next = list_valid_reg;
    bus_trig_next = 1'b0;
    if (cmd_wr) begin
      case (cmd_op)
        rmsc_pkg::CMD_CLOSE: begin
          if (is_chan) ch_next[cmd_ch[5:0]] = 1'b1;
          if (is_tree) tree_next[tree_idx] = 1'b1;
        end
        rmsc_pkg::CMD_OPEN: begin
          if (is_chan) ch_next[cmd_ch[5:0]] = 1'b0;
          if (is_tree) tree_next[tree_idx] = 1'b0;
        end
        rmsc_pkg::CMD_RESET: begin
          ch_next = '0;
          tree_next = '0;
          list_valid_next = 1'b0;
          count_next = rmsc_pkg::RST_COUNT;
          cfg_next = rmsc_pkg::RST_CFG;
        end
        default: begin
        end
      endcase
    end
    if (wr_en && addr == rmsc_pkg::OFS_CFG) cfg_next = wdata[rmsc_pkg::CFG_W-1:0];
    if (wr_en && addr == rmsc_pkg::OFS_COUNT) count_next = wdata[15:0];
    if (wr_en && addr == rmsc_pkg::OFS_LIST) begin
      list_next[wdata[5:0]] = wdata[8];
      list_valid_next = 1'b1;
    end
    if (wr_en && addr == rmsc_pkg::OFS_CTRL) bus_trig_next = wdata[0];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ch_reg <= '0;
      tree_reg <= '0;
      cfg_reg <= rmsc_pkg::RST_CFG;
      count_reg <= rmsc_pkg::RST_COUNT;
      list_reg <= '0;
      list_valid_reg <= 1'b0;
      bus_trig_reg <= 1'b0;
    end else begin
      ch_reg <= ch_next;
      tree_reg <= tree_next;
      cfg_reg <= cfg_next;
      count_reg <= count_next;
      list_reg <= list_next;
      list_valid_reg <= list_valid_next;
      bus_trig_reg <= bus_trig_next;
    end
  end

  // scan sequencer
  always_comb begin
    case (cfg_reg.trig_src)
      rmsc_pkg::RMSC_TRIG_IMM: trig_ok = 1'b1;
      rmsc_pkg::RMSC_TRIG_BUS: trig_ok = bus_trig_reg;
      rmsc_pkg::RMSC_TRIG_EXT: trig_ok = ext_trig;
      default: trig_ok = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    pos_next = pos_reg;
    pass_next = pass_reg;
    dwell_next = dwell_reg;
    scan_ch_next = scan_ch_reg;
    scan_tree_next = scan_tree_reg;
    trig_out_next = 1'b0;
    done_next = done_reg;
    if (rd_en && addr == rmsc_pkg::OFS_STATUS) done_next = 1'b0;
    case (state_reg)
      rmsc_pkg::RMSC_IDLE: begin
        if (cmd_wr && cmd_op == rmsc_pkg::CMD_INIT && list_valid_reg) begin
          pos_next = '0;
          pass_next = 16'h0001;
          state_next = rmsc_pkg::RMSC_WAIT;
        end
      end
      rmsc_pkg::RMSC_WAIT: begin
        scan_ch_next = '0;
        scan_tree_next = '0;
        if (!list_reg[pos_reg] || (four_wire && pos_reg[5])) begin
          if (pos_reg == rmsc_pkg::LIST_ENTRIES) begin
            if (cfg_reg.cont_init || pass_reg < count_reg) begin
              pass_next = 16'(pass_reg + 16'h0001);
              pos_next = '0;
            end else begin
              state_next = rmsc_pkg::RMSC_IDLE;
              done_next = 1'b1;
            end
          end else begin
            pos_next = 6'(pos_reg + 6'h01);
          end
        end else if (trig_ok) begin
          scan_ch_next[pos_reg] = 1'b1;
          if (four_wire) scan_ch_next[pos_reg + 6'(rmsc_pkg::BANK_SIZE)] = 1'b1;
          if (cfg_reg.analog_bus_port == rmsc_pkg::RMSC_PORT_ANALOG_BUS_PORT) begin
            if (!pos_reg[5]) scan_tree_next[rmsc_pkg::TR_BANK_A_SENSE] = 1'b1;
            else scan_tree_next[rmsc_pkg::TR_BANK_B_SENSE] = 1'b1;
            if (four_wire) scan_tree_next[rmsc_pkg::TR_BANK_B_CURR] = 1'b1;
          end
          trig_out_next = cfg_reg.trig_out_en;
          dwell_next = rmsc_pkg::STEP_CYC_W;
          state_next = rmsc_pkg::RMSC_DWELL;
        end
      end
      rmsc_pkg::RMSC_DWELL: begin
        if (dwell_reg == 8'h01) begin
          state_next = rmsc_pkg::RMSC_WAIT;
          if (pos_reg == rmsc_pkg::LIST_ENTRIES) begin
            if (cfg_reg.cont_init || pass_reg < count_reg) begin
              pass_next = 16'(pass_reg + 16'h0001);
              pos_next = '0;
            end else begin
              state_next = rmsc_pkg::RMSC_IDLE;
              done_next = 1'b1;
              scan_ch_next = '0;
              scan_tree_next = '0;
            end
          end else begin
            pos_next = 6'(pos_reg + 6'h01);
          end
        end else begin
          dwell_next = 8'(dwell_reg - 8'h01);
        end
      end
      default: state_next = rmsc_pkg::RMSC_IDLE;
    endcase
    if (cmd_wr && (cmd_op == rmsc_pkg::CMD_ABORT || cmd_op == rmsc_pkg::CMD_RESET)) begin
      state_next = rmsc_pkg::RMSC_IDLE;
      scan_ch_next = '0;
      scan_tree_next = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= rmsc_pkg::RMSC_IDLE;
      pos_reg <= '0;
      pass_reg <= '0;
      dwell_reg <= '0;
      scan_ch_reg <= '0;
      scan_tree_reg <= '0;
      trig_out_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      pass_reg <= pass_next;
      dwell_reg <= dwell_next;
      scan_ch_reg <= scan_ch_next;
      scan_tree_reg <= scan_tree_next;
      trig_out_reg <= trig_out_next;
      done_reg <= done_next;
    end
  end

  // read port and registered relay drive
  always_comb begin
    rdata_next = '0;
    if (rd_en) begin
      case (addr)
        rmsc_pkg::OFS_CFG: rdata_next = 32'(cfg_reg);
        rmsc_pkg::OFS_COUNT: rdata_next = 32'(count_reg);
        rmsc_pkg::OFS_STATUS: rdata_next = {16'h0000, pass_reg[7:0], 2'b00, pos_reg} |
          {29'h0, list_valid_reg, done_reg, state_reg != rmsc_pkg::RMSC_IDLE} << 24;
        rmsc_pkg::OFS_CH_LO: rdata_next = ch_drive[31:0];
        rmsc_pkg::OFS_CH_HI: rdata_next = ch_drive[63:32];
        rmsc_pkg::OFS_TREE: rdata_next = 32'(tree_drive);
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
      ch_drive <= '0;
      tree_drive <= '0;
      trig_out <= 1'b0;
      scan_busy <= 1'b0;
    end else begin
      rdata <= rdata_next;
      ch_drive <= ch_next | scan_ch_next;
      tree_drive <= tree_next | scan_tree_next;
      trig_out <= trig_out_reg;
      scan_busy <= (state_next != rmsc_pkg::RMSC_IDLE);
    end
  end
endmodule // rmsc_top
`default_nettype wire

// >>> test/rmsc_properties.sv
// port checker for rmsc_top
// assumes rmsc_pkg is compiled first; bound to rmsc_top below
`default_nettype none
module rmsc_properties (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic        ext_trig,
  input wire logic [31:0] rdata,
  input wire logic [63:0] ch_drive,
  input wire logic [4:0]  tree_drive,
  input wire logic        trig_out,
  input wire logic        scan_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cmd;
  logic [7:0] op;
  logic [7:0] ch;
  logic [1:0] cfg_reg;
  logic [1:0] cfg_next;
  assign cmd = wr_en && addr == rmsc_pkg::OFS_CMD;
  assign op = wdata[31:24];
  assign ch = wdata[7:0];
  // shadow of trigger output enable and port bits, seen only from the bus
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_en && addr == rmsc_pkg::OFS_CFG) cfg_next = {wdata[3], wdata[0]};
    if (cmd && op == rmsc_pkg::CMD_RESET) cfg_next = 2'h0;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cfg_reg <= 2'h0;
    else cfg_reg <= cfg_next;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_close;
    cmd && op == rmsc_pkg::CMD_CLOSE && ch <= rmsc_pkg::MAX_CH |=> ch_drive[$past(ch[5:0])];
  endproperty
  a_close: assert property (p_close) else $error("closed channel not driven");
  property p_tree;
    cmd && op == rmsc_pkg::CMD_CLOSE && ch >= rmsc_pkg::TREE_BASE && ch <= rmsc_pkg::TREE_LAST
      |=> tree_drive[3'($past(ch) - rmsc_pkg::TREE_BASE)];
  endproperty
  a_tree: assert property (p_tree) else $error("closed tree relay not driven");
  property p_rst_cmd;
    cmd && op == rmsc_pkg::CMD_RESET |=> ch_drive == 64'h0 && tree_drive == 5'h0;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("relay left closed by reset");
  property p_pwr;
    $rose(resetn) |-> ch_drive == 64'h0 && tree_drive == 5'h0 && !scan_busy;
  endproperty
  a_pwr: assert property (p_pwr) else $error("relay closed after power-on");
  property p_hold;
    !scan_busy ##1 !scan_busy && !cmd |=> ($past(tree_drive) & ~tree_drive) == 5'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("tree relay opened by itself");
  property p_rd;
    rd_en && addr == rmsc_pkg::OFS_TREE |=> rdata == {27'h0, $past(tree_drive)};
  endproperty
  a_rd: assert property (p_rd) else $error("tree read differs from drive");
  property p_inval;
    // a list write between the reset and the start legally revalidates the list
    cmd && op == rmsc_pkg::CMD_RESET ##1 ((cmd && op == rmsc_pkg::CMD_INIT) or
      (!(wr_en && addr == rmsc_pkg::OFS_LIST) ##1 cmd && op == rmsc_pkg::CMD_INIT))
      |=> !scan_busy[*3];
  endproperty
  a_inval: assert property (p_inval) else $error("scan ran on invalid list");
  property p_trig;
    !cfg_reg[1] [*3] |-> !trig_out;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger out while disabled");
  property p_port;
    !cfg_reg[0] && scan_busy && !cmd |=> $stable(tree_drive);
  endproperty
  a_port: assert property (p_port) else $error("scan moved tree without bus port");
  c_scan: cover property ($rose(scan_busy));
  c_trig: cover property (trig_out);
  c_tree: cover property (scan_busy && tree_drive[0]);
endmodule // rmsc_properties
bind rmsc_top rmsc_properties u_props (.clk_sys, .resetn, .addr, .wdata, .wr_en, .rd_en,
  .ext_trig, .rdata, .ch_drive, .tree_drive, .trig_out, .scan_busy);
`default_nettype wire

// >>> test/rmsc_host.sv
// host command side model: register writes and reads on the plain port
// assumes one clock; released lines show inverted values so stale data is not read
`default_nettype none
module rmsc_host (
  input  wire logic        clk_sys,
  input  wire logic [31:0] rdata,
  output var  logic [7:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr_en,
  output var  logic        rd_en,
  output var  logic        ext_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ext_trig = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
  // one-cycle external trigger, held across the sampling edge
  task automatic trig;
    @(posedge clk_sys);
    ext_trig <= 1'b1;
    @(posedge clk_sys);
    ext_trig <= 1'b0;
  endtask
  // a switched channel reaches the analog bus only through its bank tree
  task automatic link(input logic [5:0] c);
    wr(rmsc_pkg::OFS_CMD, {rmsc_pkg::CMD_CLOSE, 18'h0, c});
    wr(rmsc_pkg::OFS_CMD, {rmsc_pkg::CMD_CLOSE, 16'h0, rmsc_pkg::TREE_BASE + 8'(c[5])});
  endtask
endmodule // rmsc_host
`default_nettype wire

// >>> test/tb_relay_mux_scan_control.sv
// self-checking bench for rmsc_top against a behavioural relay model
// assumes rmsc_host drives the register port and the checker is bound
`default_nettype none
module tb_relay_mux_scan_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, wr_en, rd_en, ext_trig, trig_out, scan_busy, seen;
  logic [7:0] addr, c;
  logic [31:0] wdata, rdata, rv;
  logic [63:0] ch_drive, m_ch;
  logic [4:0] tree_drive, m_tr;
  logic [7:0] cfgs [3] = '{8'h09, 8'h00, 8'h05};
  int err_total, check_count, trigs;
  rmsc_top DUT (.clk_sys, .resetn, .addr, .wdata, .wr_en, .rd_en, .ext_trig, .rdata,
    .ch_drive, .tree_drive, .trig_out, .scan_busy);
  rmsc_host host (.clk_sys, .rdata, .addr, .wdata, .wr_en, .rd_en, .ext_trig);
  task automatic chk(input string n, input logic [68:0] s, input logic [68:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] ch);
    host.wr(rmsc_pkg::OFS_CMD, {op, 16'h0, ch});
    if (op == rmsc_pkg::CMD_RESET) begin
      m_ch = 64'h0;
      m_tr = 5'h0;
    end else if (ch <= rmsc_pkg::MAX_CH) m_ch[ch[5:0]] = op == rmsc_pkg::CMD_CLOSE;
    else if (ch >= rmsc_pkg::TREE_BASE && ch <= rmsc_pkg::TREE_LAST)
      m_tr[3'(ch - rmsc_pkg::TREE_BASE)] = op == rmsc_pkg::CMD_CLOSE;
    #1;
    chk("relays", {tree_drive, ch_drive}, {m_tr, m_ch});
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    host.rd(a, rv);
    chk(n, 69'(rv), 69'(e));
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
  initial begin
    err_total = 0;
    check_count = 0;
    m_ch = 64'h0;
    m_tr = 5'h0;
    resetn = 1'b0;
    void'($urandom(25113));
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk("relays", {tree_drive, ch_drive}, 69'h0);
    rchk("count", rmsc_pkg::OFS_COUNT, 32'h1);
    rchk("cfg", rmsc_pkg::OFS_CFG, 32'h0);
    rchk("status", rmsc_pkg::OFS_STATUS, 32'h0);
    $display("test defaults done");
    host.link(6'd23);
    m_ch[23] = 1'b1;
    m_tr[0] = 1'b1;
    cmd(rmsc_pkg::CMD_CLOSE, 8'd40);
    repeat (60) begin
      c = 8'($urandom_range(95));
      cmd($urandom_range(1) ? rmsc_pkg::CMD_CLOSE : rmsc_pkg::CMD_OPEN, c);
    end
    rchk("ch_lo", rmsc_pkg::OFS_CH_LO, m_ch[31:0]);
    rchk("ch_hi", rmsc_pkg::OFS_CH_HI, m_ch[63:32]);
    rchk("tree", rmsc_pkg::OFS_TREE, {27'h0, m_tr});
    rchk("unmapped", 8'h40, 32'h0);
    $display("test switching done");
    host.wr(rmsc_pkg::OFS_CFG, 32'($urandom_range(127)));
    host.wr(rmsc_pkg::OFS_COUNT, 32'($urandom_range(65535)));
    host.wr(rmsc_pkg::OFS_LIST, 32'h105);
    cmd(rmsc_pkg::CMD_RESET, 8'h0);
    host.wr(rmsc_pkg::OFS_CMD, {rmsc_pkg::CMD_INIT, 24'h0});
    repeat (3) @(posedge clk_sys);
    #1;
    chk("busy", 69'(scan_busy), 69'h0);
    rchk("cfg", rmsc_pkg::OFS_CFG, 32'h0);
    rchk("count", rmsc_pkg::OFS_COUNT, 32'h1);
    rchk("status", rmsc_pkg::OFS_STATUS, 32'h0);
    $display("test reset command done");
    host.wr(rmsc_pkg::OFS_LIST, 32'h105);
    host.wr(rmsc_pkg::OFS_LIST, 32'h128);
    foreach (cfgs[i]) begin
      host.wr(rmsc_pkg::OFS_CFG, 32'(cfgs[i]));
      host.wr(rmsc_pkg::OFS_CMD, {rmsc_pkg::CMD_INIT, 24'h0});
      seen = 1'b0;
      trigs = 0;
      repeat (200) begin
        @(posedge clk_sys);
        #1;
        trigs += int'(trig_out);
        if (ch_drive[5]) begin
          seen = 1'b1;
          chk("tree_a", 69'(tree_drive), 69'({cfgs[i][2], 1'b0, cfgs[i][0]}));
          if (cfgs[i][2]) chk("pair", 69'(ch_drive[37]), 69'h1);
        end
        if (ch_drive[40]) chk("tree_b", 69'(tree_drive), 69'({cfgs[i][0], 1'b0}));
      end
      chk("seen", 69'(seen), 69'h1);
      chk("trigs", 69'(trigs), cfgs[i][3] ? 69'h2 : 69'h0);
      chk("after", {tree_drive, ch_drive}, {m_tr, m_ch});
      chk("idle", 69'(scan_busy), 69'h0);
    end
    // one pass, last position, done set; the read clears done
    rchk("status", rmsc_pkg::OFS_STATUS, 32'h0600013f);
    rchk("status", rmsc_pkg::OFS_STATUS, 32'h0400013f);
    $display("test scanning done");
    // bus then external trigger: the scan parks on channel 5 until its trigger comes
    for (int t = 1; t < 3; t++) begin
      host.wr(rmsc_pkg::OFS_CFG, 32'(t) << 5);
      host.wr(rmsc_pkg::OFS_CMD, {rmsc_pkg::CMD_INIT, 24'h0});
      repeat (30) @(posedge clk_sys);
      #1;
      chk("held", 69'(ch_drive), 69'h0);
      chk("busy", 69'(scan_busy), 69'h1);
      if (t == 1) host.wr(rmsc_pkg::OFS_CTRL, 32'h1);
      else host.trig();
      repeat (3) @(posedge clk_sys);
      #1;
      chk("stepped", 69'(ch_drive), 69'h20);
      cmd(rmsc_pkg::CMD_ABORT, 8'h0);
    end
    $display("test triggers done");
    host.link(6'd40);
    m_ch[40] = 1'b1;
    m_tr[1] = 1'b1;
    #1;
    chk("link", {tree_drive, ch_drive}, {m_tr, m_ch});
    @(posedge clk_sys);
    resetn <= 1'b0;
    m_ch = 64'h0;
    m_tr = 5'h0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk("relays", {tree_drive, ch_drive}, {m_tr, m_ch});
    rchk("cfg", rmsc_pkg::OFS_CFG, 32'h0);
    rchk("status", rmsc_pkg::OFS_STATUS, 32'h0);
    $display("test mid-run reset done");
    test_done();
  end
endmodule // tb_relay_mux_scan_control
`default_nettype wire
